// file: src/mwt_wave_table.sv
// microstep wave table: quarter wave store, expansion and coil current sequencer
`timescale 1ns/1ps
`include "mwt_map.svh"

// Contract
// - store first quadrant, mirror to full turn
// - 10-bit position counter addresses full wave
// - 256 single bits in eight 32-bit words
// - add slope, or slope plus one, per bit
// - slope codes mean -1, 0, 1 or 2
// - three boundaries split quadrant into four segments
// - every microstep updates both readable coil currents
// - sine start field gives value at zero
// - cosine start field gives 90 degree value
// - table resets to a sine shape
// - segment select resets to 128/255/255, 10/01/01/01
// - start word resets to 0 and 247
// - table words reset to printed patterns
module mwt_wave_table (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic [7:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  input  wire logic              step_req,
  input  wire logic              step_dir,
  output logic      [9:0]        microstep_position_counter,
  output mwt_pkg::mwt_coil_s     coil_current
);
  import mwt_pkg::*;

  // ==========================================================
  // constants
  localparam logic [31:0] WORD_RST [8] = '{
    `MWT_WORD0_RST, `MWT_WORD1_RST, `MWT_WORD2_RST, `MWT_WORD3_RST,
    `MWT_WORD4_RST, `MWT_WORD5_RST, `MWT_WORD6_RST, `MWT_WORD7_RST
  };
  localparam logic [9:0] QUARTER = 10'h100; // phase offset of the second coil

  // ==========================================================
  // state
  logic        [31:0] wave_bits_word [8];      // quarter wave, one bit per entry
  logic        [31:0] next_wave_bits_word [8];
  mwt_seg_s           wave_segment_select;     // boundaries and slopes
  mwt_seg_s           next_wave_segment_select;
  mwt_start_s         wave_start_values;       // absolute start values
  mwt_start_s         next_wave_start_values;
  mwt_bus_e           bus_state;               // bus answer phase
  mwt_bus_e           next_bus_state;
  logic        [31:0] next_readdata;
  logic        [9:0]  pos;                     // microstep position
  logic        [9:0]  next_pos;
  logic signed [9:0]  sin_t;                   // table value, first coil
  logic signed [9:0]  next_sin_t;
  logic signed [9:0]  cos_t;                   // table value, second coil
  logic signed [9:0]  next_cos_t;
  mwt_coil_s          next_coil;
  logic        [255:0] wave_flat;              // table as one vector
  logic        [9:0]  cpos;                    // second coil position
  logic        [9:0]  next_cpos;

  // ==========================================================
  // helpers

  // table index of a position: odd quadrants run backwards
  function automatic logic [8:0] table_idx(logic [9:0] p);
    logic [8:0] k;
    k = {1'b0, p[7:0]};
    if (p[`MWT_ODD_QUAD_BIT]) begin
      k = 9'h100 - k;
    end
    return k;
  endfunction

  // increment from table index k to k+1
  function automatic logic signed [9:0] wave_inc(logic [255:0] bits, mwt_seg_s seg,
                                                 logic [7:0] k);
    logic [1:0] code;
    // segment choice by boundaries
    if (k < seg.segment_boundary_first) begin
      code = seg.slope_code_seg_zero;
    end else if (k < seg.segment_boundary_second) begin
      code = seg.slope_code_seg_one;
    end else if (k < seg.segment_boundary_third) begin
      code = seg.slope_code_seg_two;
    end else begin
      code = seg.slope_code_seg_three;
    end
    // code 0..3 means slope -1..2, entry bit adds one
    return $signed({8'h00, code}) - 10'sd1 + $signed({9'h000, bits[k]});
  endfunction

  // move a table value one position, either way
  function automatic logic signed [9:0] step_t(logic signed [9:0] t, logic [8:0] kc,
                                               logic [8:0] kn, logic [255:0] bits,
                                               mwt_seg_s seg);
    logic signed [9:0] r;
    if (kn > kc) begin
      r = t + wave_inc(bits, seg, kc[7:0]);
    end else begin
      r = t - wave_inc(bits, seg, kn[7:0]);
    end
    return r;
  endfunction

  // byte lane merge for writes
  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // flatten the eight words into the 256 entries
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wave_flat[i*32 +: 32] = wave_bits_word[i];
    end
  end

  // handshake: one wait cycle for every access
  assign waitrequest = (read | write) & (bus_state == BUS_IDLE);

  assign microstep_position_counter = pos;
  assign cpos = pos + QUARTER;
  assign next_cpos = next_pos + QUARTER;

  // ==========================================================
  // register bus: decode, read mux and write merge
  always_comb begin
    next_bus_state = bus_state;
    next_readdata = readdata;
    next_wave_bits_word = wave_bits_word;
    next_wave_segment_select = wave_segment_select;
    next_wave_start_values = wave_start_values;
    unique case (bus_state)
      BUS_IDLE: begin
        // request seen, data prepared for the answer cycle
        if (read | write) begin
          next_bus_state = BUS_ACK;
        end
        if (read) begin
          next_readdata = 32'h0000_0000; // unmapped reads give zero
          if (address[7:5] == `MWT_OFS_WORD_BASE >> 5 && address[1:0] == 2'b00) begin
            next_readdata = wave_bits_word[address[4:2]];
          end else begin
            unique case (address)
              `MWT_OFS_SEG:   next_readdata = wave_segment_select;
              `MWT_OFS_START: next_readdata = wave_start_values;
              `MWT_OFS_POS:   next_readdata = {22'h000000, pos};
              `MWT_OFS_COIL: begin
                next_readdata = {{7{coil_current.coil_two_current_value[8]}},
                                 coil_current.coil_two_current_value,
                                 {7{coil_current.coil_one_current_value[8]}},
                                 coil_current.coil_one_current_value};
              end
              default: next_readdata = 32'h0000_0000;
            endcase
          end
        end
      end
      BUS_ACK: begin
        // write takes effect on the edge that ends the access, one cycle after the wait
        next_bus_state = BUS_IDLE;
        if (write) begin
          if (address[7:5] == `MWT_OFS_WORD_BASE >> 5 && address[1:0] == 2'b00) begin
            next_wave_bits_word[address[4:2]] =
              be_merge(wave_bits_word[address[4:2]], writedata, byteenable);
          end else if (address == `MWT_OFS_SEG) begin
            next_wave_segment_select = be_merge(wave_segment_select, writedata, byteenable);
          end else if (address == `MWT_OFS_START) begin
            next_wave_start_values = be_merge(wave_start_values, writedata, byteenable);
            // reserved bytes stay zero
            next_wave_start_values.rsv_hi = 8'h00;
            next_wave_start_values.rsv_lo = 8'h00;
          end
          // position and coil words are read only; others ignored
        end
      end
    endcase
  end

  // registers of the bus side
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      bus_state <= BUS_IDLE;
      readdata <= 32'h0000_0000;
      wave_bits_word <= WORD_RST;
      wave_segment_select <= `MWT_SEG_RST;
      wave_start_values <= `MWT_START_RST;
    end else begin
      bus_state <= next_bus_state;
      readdata <= next_readdata;
      wave_bits_word <= next_wave_bits_word;
      wave_segment_select <= next_wave_segment_select;
      wave_start_values <= next_wave_start_values;
    end
  end

  // ==========================================================
  // sequencer: incremental walk, reload at zero, expansion
  // a table change between zero passes alters the increments at once; values match the new table only after the next pass
  always_comb begin
    next_pos = pos;
    next_sin_t = sin_t;
    next_cos_t = cos_t;
    if (step_req) begin
      next_pos = step_dir ? pos - 10'h001 : pos + 10'h001;
      if (next_pos == 10'h000) begin
        // absolute reload wipes drift from table edits
        next_sin_t = $signed({2'b00, wave_start_values.sine_start_value});
        next_cos_t = $signed({2'b00, wave_start_values.cosine_start_value});
      end else begin
        next_sin_t = step_t(sin_t, table_idx(pos), table_idx(next_pos),
                            wave_flat, wave_segment_select);
        next_cos_t = step_t(cos_t, table_idx(cpos), table_idx(next_cpos),
                            wave_flat, wave_segment_select);
      end
    end
    // second half turn is the negated first half
    next_coil.coil_one_current_value =
      9'(next_pos[`MWT_HALF_TURN_BIT] ? -next_sin_t : next_sin_t);
    next_coil.coil_two_current_value =
      9'(next_cpos[`MWT_HALF_TURN_BIT] ? -next_cos_t : next_cos_t);
  end

  // registers of the sequencer
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pos <= `MWT_POS_RST;
      sin_t <= 10'sd0;
      cos_t <= 10'sd0;
      coil_current <= '0;
    end else begin
      pos <= next_pos;
      sin_t <= next_sin_t;
      cos_t <= next_cos_t;
      coil_current <= next_coil;
    end
  end

  // ==========================================================
  // assertions
  a_pos_forward_wrap: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step_req && !step_dir) |=> pos == 10'($past(pos) + 10'h001))
    else $error("position did not advance by one");

  a_zero_reload_sin: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step_req && next_pos == 10'h000) |=>
      sin_t == $signed({2'b00, $past(wave_start_values.sine_start_value)}))
    else $error("sine value not reloaded at zero");

  a_zero_reload_cos: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step_req && next_pos == 10'h000) |=>
      coil_current.coil_two_current_value ==
        9'($signed({2'b00, $past(wave_start_values.cosine_start_value)})))
    else $error("cosine value not reloaded at zero");

  a_slope_add: assert property (@(posedge clk_sys) disable iff (!nrst)
    (step_req && !step_dir && pos[9:8] == 2'b00) |=>
      sin_t == $past(sin_t) + $past(wave_inc(wave_flat, wave_segment_select, pos[7:0])))
    else $error("wrong increment in first quadrant");

  a_half_negate: assert property (@(posedge clk_sys) disable iff (!nrst)
    coil_current.coil_one_current_value == 9'(pos[9] ? -sin_t : sin_t))
    else $error("first coil sign does not follow half turn");

  a_coil_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !step_req |=> $stable(coil_current) && $stable(pos))
    else $error("coil values changed without a microstep");

  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!nrst)
    ((read || write) && waitrequest) |=> !waitrequest ##1 (bus_state == BUS_IDLE))
    else $error("bus answer not given after one wait cycle");

  a_reset_seg: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> wave_segment_select == `MWT_SEG_RST && wave_start_values == `MWT_START_RST)
    else $error("segment or start word not at default after reset");

  a_reset_table: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(nrst) |-> wave_bits_word[0] == `MWT_WORD0_RST && wave_bits_word[7] == `MWT_WORD7_RST)
    else $error("table words not at default after reset");

endmodule

// file: src/mwt_map.svh
// register offsets, field positions and reset values of the microstep wave table
`ifndef MWT_MAP_SVH
`define MWT_MAP_SVH

// ==========================================================
// register byte offsets (word aligned)
`define MWT_OFS_WORD_BASE 8'h00
`define MWT_OFS_SEG       8'h20
`define MWT_OFS_START     8'h24
`define MWT_OFS_POS       8'h28
`define MWT_OFS_COIL      8'h2c

// ==========================================================
// field positions inside the readable words
`define MWT_COIL_TWO_LSB  16
`define MWT_HALF_TURN_BIT 9
`define MWT_ODD_QUAD_BIT  8

// ==========================================================
// reset values: default sine shape
`define MWT_WORD0_RST 32'haaaab554
`define MWT_WORD1_RST 32'h4a9554aa
`define MWT_WORD2_RST 32'h24492929
`define MWT_WORD3_RST 32'h10104222
`define MWT_WORD4_RST 32'hfbffffff
`define MWT_WORD5_RST 32'hb5bb777d
`define MWT_WORD6_RST 32'h49295556
`define MWT_WORD7_RST 32'h00404222
`define MWT_SEG_RST   32'hffff8056
`define MWT_START_RST 32'h00f70000
`define MWT_POS_RST   10'h000

`endif

// file: src/mwt_pkg.sv
// types shared by the microstep wave table
package mwt_pkg;

  // ==========================================================
  // segment select word: boundaries and slope codes
  typedef struct packed {
    logic [7:0] segment_boundary_third;
    logic [7:0] segment_boundary_second;
    logic [7:0] segment_boundary_first;
    logic [1:0] slope_code_seg_three;
    logic [1:0] slope_code_seg_two;
    logic [1:0] slope_code_seg_one;
    logic [1:0] slope_code_seg_zero;
  } mwt_seg_s;

  // ==========================================================
  // start word: reserved bytes always read zero
  typedef struct packed {
    logic [7:0] rsv_hi;
    logic [7:0] cosine_start_value;
    logic [7:0] rsv_lo;
    logic [7:0] sine_start_value;
  } mwt_start_s;

  // ==========================================================
  // both coil current values, signed
  typedef struct packed {
    logic signed [8:0] coil_two_current_value;
    logic signed [8:0] coil_one_current_value;
  } mwt_coil_s;

  // bus answer sequencing
  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_ACK
  } mwt_bus_e;

endpackage

// file: testbench/tb.sv
// self-checking bench of the microstep wave table
`timescale 1ns/1ps
`include "mwt_map.svh"

module tb;
  import mwt_pkg::*;
  // ==========================================================
  // design signals
  logic        clk_sys;
  logic        nrst;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        step_req;
  logic        step_dir;
  logic [9:0]  microstep_position_counter;
  mwt_coil_s   coil_current;
  // ==========================================================
  // reference state
  int          n_mismatch;   // failed comparisons
  int          total_checks; // all comparisons
  logic [31:0] tbl [8];      // bench copy of the quarter bits
  logic [31:0] seg_w;        // bench copy of segment select
  logic [31:0] start_w;      // bench copy of start word
  int          q [257];      // quarter wave, entry zero taken as 0
  logic [9:0]  pos;          // expected position
  bit          loaded;       // coils known only after a zero pass
  logic [31:0] rd;           // last read word

  mwt_wave_table mwt_wave_table_i (
    .clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .step_req(step_req), .step_dir(step_dir),
    .microstep_position_counter(microstep_position_counter), .coil_current(coil_current));

  // 100 ns system clock
  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ==========================================================
  // compare tasks and verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_coil(input mwt_coil_s got, input mwt_coil_s exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // avalon master: hold request until waitrequest seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk_sys);
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    // look at waitrequest once it has settled in each cycle; the edge after a low one ends the access
    #1;
    while (waitrequest !== 1'b0) begin
      @(posedge clk_sys);
      #1;
    end
    rd = readdata; // stands at the edge that ends the access
    @(posedge clk_sys);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    cmp(rd, exp);
  endtask

  // ==========================================================
  // reference wave: slope code c adds c-1, plus the entry bit
  function automatic void rebuild();
    int c;
    q[0] = 0;
    for (int k = 0; k < 256; k++) begin
      c = (k < seg_w[15:8]) ? 0 : (k < seg_w[23:16]) ? 1 : (k < seg_w[31:24]) ? 2 : 3;
      q[k+1] = q[k] + int'(seg_w[2*c +: 2]) - 1 + int'(tbl[k/32][k%32]);
    end
  endfunction

  // quarter value at a position: odd quadrants walk backwards
  function automatic int mag(input logic [9:0] p);
    return p[8] ? q[256 - int'(p[7:0])] : q[p[7:0]];
  endfunction

  // start value anchors each coil at its reload point, upper half turn negated as a whole
  function automatic mwt_coil_s exp_coil(input logic [9:0] p);
    mwt_coil_s  e;
    logic [9:0] c;
    int         a;
    int         b;
    c = p + 10'h100;
    a = int'(start_w[7:0]) + mag(p) - q[0];
    b = int'(start_w[23:16]) + mag(c) - q[256];
    e.coil_one_current_value = 9'(p[9] ? -a : a);
    e.coil_two_current_value = 9'(c[9] ? -b : b);
    return e;
  endfunction

  // ==========================================================
  // n microsteps per call, position checked the cycle after, coils only once loaded
  task automatic step(input logic d, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      step_req <= 1'b1;
      step_dir <= d;
      @(posedge clk_sys);
      step_req <= 1'b0;
      pos = d ? pos - 10'h001 : pos + 10'h001;
      if (pos == 10'h000) loaded = 1;
      #1;
      cmp({22'h0, microstep_position_counter}, {22'h0, pos});
      if (loaded) cmp_coil(coil_current, exp_coil(pos));
    end
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    #1;
    tbl = '{32'haaaab554, 32'h4a9554aa, 32'h24492929, 32'h10104222,
            32'hfbffffff, 32'hb5bb777d, 32'h49295556, 32'h00404222};
    seg_w = 32'hffff8056;
    start_w = 32'h00f70000;
    pos = 10'h000;
    loaded = 0;
    rebuild();
  endtask

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
    step_req = 1'b0;
    step_dir = 1'b0;
    do_reset();
    cmp_coil(coil_current, '0);
    for (int i = 0; i < 8; i++) rd_chk(`MWT_OFS_WORD_BASE + 8'(4*i), tbl[i]);
    rd_chk(`MWT_OFS_SEG, 32'hffff8056);
    rd_chk(`MWT_OFS_START, 32'h00f70000);
    $display("test reset_values done");
    // first turn ends in the first reload, then default wave both ways across zero
    step(1'b0, 1024);
    step(1'b0, 1024);
    step(1'b1, 300);
    step(1'b0, 300);
    rd_chk(`MWT_OFS_POS, 32'h0);
    rd_chk(`MWT_OFS_COIL, 32'h00f70000);
    $display("test default_wave done");
    // slope codes 0, 1 and 3 in use, byte lanes, read-only and unmapped places
    bus(1'b1, `MWT_OFS_SEG, 32'h80402013, 4'hf);
    bus(1'b1, `MWT_OFS_START, 32'hff30ff00, 4'hf);
    bus(1'b1, `MWT_OFS_WORD_BASE + 8'h1c, 32'h12345678, 4'b0100);
    bus(1'b1, `MWT_OFS_POS, 32'h155, 4'hf);
    bus(1'b1, 8'h30, 32'h5a5a5a5a, 4'hf);
    seg_w = 32'h80402013;
    start_w = 32'h00300000;
    tbl[7] = {tbl[7][31:24], 8'h34, tbl[7][15:0]};
    rebuild();
    loaded = 0;
    rd_chk(`MWT_OFS_SEG, seg_w);
    rd_chk(`MWT_OFS_START, start_w);
    rd_chk(`MWT_OFS_WORD_BASE + 8'h1c, tbl[7]);
    rd_chk(`MWT_OFS_POS, 32'h0);
    rd_chk(8'h30, 32'h0);
    // new increments at once, the new wave exactly after the next zero pass
    step(1'b0, 1024);
    step(1'b0, 1024);
    step(1'b1, 1024);
    $display("test custom_wave done");
    // reset in mid-run restores the default shape
    step(1'b0, 5);
    do_reset();
    cmp({22'h0, microstep_position_counter}, 32'h0);
    cmp_coil(coil_current, '0);
    rd_chk(`MWT_OFS_SEG, 32'hffff8056);
    rd_chk(`MWT_OFS_WORD_BASE + 8'h1c, 32'h00404222);
    $display("test second_reset done");
    final_report();
  end

  // watchdog: the whole sequence needs about 11600 cycles
  initial begin
    repeat (40000) @(posedge clk_sys);
    $display("watchdog expired");
    n_mismatch++;
    final_report();
  end
endmodule
